// *** logic/mso_motion_detect.sv ***
// Wake-on-motion detector: compares accelerometer samples against a
// reference. Assumes samples arrive on the system clock domain.
`timescale 1ns/100ps
module mso_motion_detect (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Control
	input wire logic i_enable,
	input wire logic i_mode,
	input wire logic i_clear,
	input wire logic i_low_power,
	input wire logic [7:0] i_threshold,
	// Samples
	input wire mso_pkg::mso_axes_s i_sample,
	input wire logic i_sample_valid,
	// Result
	output logic o_motion
);
	import mso_pkg::*;

	mso_wom_state_s state_reg;
	mso_wom_state_s state_next;

	// Absolute difference of two signed axis words
	function automatic logic [16:0] abs_diff(logic signed [15:0] a,
		logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		if (d[16]) begin
			abs_diff = 17'(-d);
		end else begin
			abs_diff = 17'(d);
		end
	endfunction

	// Reference capture and comparison
	always_comb begin
		logic over;
		logic [16:0] limit;
		over = 1'b0;
		limit = {9'h0, i_threshold};
		state_next = state_reg;
		state_next.motion = 1'b0;
		state_next.low_power_d = i_low_power;
		over = (abs_diff(i_sample.x, state_reg.ref_sample.x) > limit)
			|| (abs_diff(i_sample.y, state_reg.ref_sample.y) > limit)
			|| (abs_diff(i_sample.z, state_reg.ref_sample.z) > limit);
		if (i_clear || !i_enable) begin
			state_next.ref_valid = 1'b0;
		end else if (i_low_power && !state_reg.low_power_d) begin
			state_next.ref_valid = 1'b0; // New low-power entry, new reference
		end else if (i_sample_valid && i_low_power) begin
			if (!state_reg.ref_valid) begin
				state_next.ref_sample = i_sample;
				state_next.ref_valid = 1'b1;
			end else begin
				state_next.motion = over;
				if (i_mode) begin
					state_next.ref_sample = i_sample;
				end
			end
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_motion = state_reg.motion;

endmodule

// *** logic/mso_sensor_ctrl.sv ***
// Sensor output registers and path/user control for a six-axis sensor.
// Assumes the serial front end hands over decoded register accesses on
// the system clock, and sensor paths deliver words on the same clock.
//
// Function
// - Temperature word read as high byte at 0x41, low byte at 0x42.
// - Rate high bytes for X, Y, Z readable at 0x43, 0x45, 0x47.
// - Rate word is sensitivity times rate; 131 counts per dps at +-250.
// - Writing accel path reset bit resets accel path, outputs kept.
// - Writing temp path reset bit resets temp path, outputs kept.
// - Motion detect enable bit turns wake-on-motion logic on or off.
// - Compare mode: 0 against first low-power sample, 1 against previous.
// - FIFO enable one gives FIFO mode; zero blocks serial FIFO access.
// - FIFO enable does not gate internal writes into the FIFO.
// - Two-wire disable shuts the two-wire target, leaving SPI only.
// - FIFO reset bit resets FIFO, self-clears after one internal clock.
// - Signal-conditioning reset resets all paths and clears output words.
`timescale 1ns/100ps
module mso_sensor_ctrl (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Register port from the serial front end
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_read,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Sensor words from the signal paths
	input wire logic [15:0] i_temp_word,
	input wire logic i_temp_valid,
	input wire mso_pkg::mso_axes_s i_rate_word,
	input wire logic i_rate_valid,
	// Accelerometer samples and low-power state for motion detection
	input wire mso_pkg::mso_axes_s i_accel_sample,
	input wire logic i_accel_valid,
	input wire logic i_low_power,
	input wire logic [7:0] i_motion_threshold,
	// Path, FIFO and two-wire controls, and the wake-on-motion output
	output logic o_accel_path_reset,
	output logic o_temp_path_reset,
	output logic o_rate_path_reset,
	output logic o_fifo_enable,
	output logic o_fifo_reset,
	output logic o_two_wire_disable,
	output logic o_wake_on_motion
);
	import mso_pkg::*;

	mso_ctrl_state_s state_reg;
	mso_ctrl_state_s state_next;
	logic motion;

	// Register read data for an address
	function automatic logic [7:0] read_data(logic [7:0] addr,
		mso_ctrl_state_s s);
		logic [7:0] d;
		d = MSO_UNMAPPED_DATA;
		if (addr == MSO_ADDR_TEMP_HIGH) begin
			d = s.temp_word[15:8];
		end else if (addr == MSO_ADDR_TEMP_LOW) begin
			d = s.temp_word[7:0];
		end else if (addr == MSO_ADDR_RATE_X_HIGH) begin
			d = s.rate.x[15:8];
		end else if (addr == MSO_ADDR_RATE_X_LOW) begin
			d = s.rate.x[7:0];
		end else if (addr == MSO_ADDR_RATE_Y_HIGH) begin
			d = s.rate.y[15:8];
		end else if (addr == MSO_ADDR_RATE_Y_LOW) begin
			d = s.rate.y[7:0];
		end else if (addr == MSO_ADDR_RATE_Z_HIGH) begin
			d = s.rate.z[15:8];
		end else if (addr == MSO_ADDR_RATE_Z_LOW) begin
			d = s.rate.z[7:0];
		end else if (addr == MSO_ADDR_PATH_RESET) begin
			d = MSO_BYTE_RESET; // Reset bits self-clear
		end else if (addr == MSO_ADDR_MOTION_CTRL) begin
			d[MSO_BIT_MOTION_ENABLE] = s.motion_detect_enable;
			d[MSO_BIT_MOTION_MODE] = s.motion_compare_mode;
		end else if (addr == MSO_ADDR_USER_CTRL) begin
			d[MSO_BIT_FIFO_ENABLE] = s.fifo_enable;
			d[MSO_BIT_TWO_WIRE_DIS] = s.two_wire_disable;
			d[MSO_BIT_FIFO_RESET] = s.fifo_reset;
		end
		return d;
	endfunction

	// Next-state logic: divider, sensor capture, register writes and reads
	always_comb begin
		logic wr_path;
		logic wr_motion;
		logic wr_user;
		logic sig_cond;
		wr_path = i_reg_write && (i_reg_addr == MSO_ADDR_PATH_RESET);
		wr_motion = i_reg_write && (i_reg_addr == MSO_ADDR_MOTION_CTRL);
		wr_user = i_reg_write && (i_reg_addr == MSO_ADDR_USER_CTRL);
		sig_cond = wr_user && i_reg_wdata[MSO_BIT_SIGNAL_CONDITIONING_RESET];
		state_next = state_reg;

		// Internal clock enable, one pulse per internal clock period
		state_next.int_tick = 1'b0;
		if (state_reg.div_count == MSO_INT_CLK_DIV - 1'b1) begin
			state_next.div_count = '0;
			state_next.int_tick = 1'b1;
		end else begin
			state_next.div_count = state_reg.div_count + 1'b1;
		end

		// Capture sensor words; path resets leave them untouched
		if (i_temp_valid) begin
			state_next.temp_word = i_temp_word;
		end
		if (i_rate_valid) begin
			state_next.rate = i_rate_word;
		end

		// Path reset pulses last one cycle
		state_next.accel_path_reset = wr_path
			&& i_reg_wdata[MSO_BIT_ACCEL_PATH_RST];
		state_next.temp_path_reset = wr_path
			&& i_reg_wdata[MSO_BIT_TEMP_PATH_RST];
		state_next.rate_path_reset = 1'b0;

		// Full conditioning reset clears every output word
		if (sig_cond) begin
			state_next.accel_path_reset = 1'b1;
			state_next.temp_path_reset = 1'b1;
			state_next.rate_path_reset = 1'b1;
			state_next.temp_word = MSO_WORD_RESET;
			state_next.rate = '0;
		end

		if (wr_motion) begin
			state_next.motion_detect_enable =
				i_reg_wdata[MSO_BIT_MOTION_ENABLE];
			state_next.motion_compare_mode =
				i_reg_wdata[MSO_BIT_MOTION_MODE];
		end

		// FIFO reset holds through one whole internal clock period
		if (state_reg.fifo_reset && state_reg.int_tick) begin
			if (state_reg.fifo_reset_tick_seen) begin
				state_next.fifo_reset = 1'b0;
				state_next.fifo_reset_tick_seen = 1'b0;
			end else begin
				state_next.fifo_reset_tick_seen = 1'b1;
			end
		end

		if (wr_user) begin
			state_next.fifo_enable =
				i_reg_wdata[MSO_BIT_FIFO_ENABLE];
			state_next.two_wire_disable =
				i_reg_wdata[MSO_BIT_TWO_WIRE_DIS];
			if (i_reg_wdata[MSO_BIT_FIFO_RESET]) begin
				state_next.fifo_reset = 1'b1;
				state_next.fifo_reset_tick_seen = 1'b0;
			end
		end

		// Read answer one cycle after the strobe
		state_next.rvalid = i_reg_read;
		if (i_reg_read) begin
			state_next.rdata = read_data(i_reg_addr, state_reg);
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Wake-on-motion detector, cleared by the accelerometer path reset
	mso_motion_detect u_motion (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_enable(state_reg.motion_detect_enable),
		.i_mode(state_reg.motion_compare_mode),
		.i_clear(state_reg.accel_path_reset),
		.i_low_power(i_low_power),
		.i_threshold(i_motion_threshold),
		.i_sample(i_accel_sample),
		.i_sample_valid(i_accel_valid),
		.o_motion(motion)
	);

	// Outputs straight from state flops
	assign o_reg_rdata = state_reg.rdata;
	assign o_reg_rvalid = state_reg.rvalid;
	assign o_accel_path_reset = state_reg.accel_path_reset;
	assign o_temp_path_reset = state_reg.temp_path_reset;
	assign o_rate_path_reset = state_reg.rate_path_reset;
	// FIFO enable gates only host access; internal writes are not gated
	assign o_fifo_enable = state_reg.fifo_enable;
	assign o_fifo_reset = state_reg.fifo_reset;
	assign o_two_wire_disable = state_reg.two_wire_disable;
	assign o_wake_on_motion = motion;

endmodule

// *** pkg/mso_pkg.sv ***
// Shared constants, field layouts and state types for the sensor readout
// and path control block. Assumes a single 100 MHz system clock.
package mso_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] MSO_ADDR_TEMP_HIGH = 8'h41;
	localparam logic [7:0] MSO_ADDR_TEMP_LOW = 8'h42;
	localparam logic [7:0] MSO_ADDR_RATE_X_HIGH = 8'h43;
	localparam logic [7:0] MSO_ADDR_RATE_X_LOW = 8'h44;
	localparam logic [7:0] MSO_ADDR_RATE_Y_HIGH = 8'h45;
	localparam logic [7:0] MSO_ADDR_RATE_Y_LOW = 8'h46;
	localparam logic [7:0] MSO_ADDR_RATE_Z_HIGH = 8'h47;
	localparam logic [7:0] MSO_ADDR_RATE_Z_LOW = 8'h48;
	localparam logic [7:0] MSO_ADDR_PATH_RESET = 8'h68;
	localparam logic [7:0] MSO_ADDR_MOTION_CTRL = 8'h69;
	localparam logic [7:0] MSO_ADDR_USER_CTRL = 8'h6a;

	// Field positions
	localparam int MSO_BIT_ACCEL_PATH_RST = 1;
	localparam int MSO_BIT_TEMP_PATH_RST = 0;
	localparam int MSO_BIT_MOTION_ENABLE = 7;
	localparam int MSO_BIT_MOTION_MODE = 6;
	localparam int MSO_BIT_FIFO_ENABLE = 6;
	localparam int MSO_BIT_TWO_WIRE_DIS = 4;
	localparam int MSO_BIT_FIFO_RESET = 2;
	localparam int MSO_BIT_SIGNAL_CONDITIONING_RESET = 0;

	// Reset values
	localparam logic [15:0] MSO_WORD_RESET = 16'h0000;
	localparam logic [7:0] MSO_BYTE_RESET = 8'h00;
	localparam logic [7:0] MSO_UNMAPPED_DATA = 8'h00;

	// Rate sensitivity at the smallest full-scale range, counts per dps
	localparam int MSO_RATE_SENS_LSB_PER_DPS = 131;

	// Clock rates and the divider that makes the internal clock tick
	localparam longint MSO_SYS_CLK_HZ = 100_000_000;
	localparam longint MSO_INT_CLK_HZ = 20_000_000;
	localparam int MSO_DIV_W = 3;
	localparam logic [MSO_DIV_W-1:0] MSO_INT_CLK_DIV =
		MSO_DIV_W'(MSO_SYS_CLK_HZ / MSO_INT_CLK_HZ);

	// Three signed axis words travelling together
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mso_axes_s;

	// Motion detector state
	typedef struct packed {
		mso_axes_s ref_sample;
		logic ref_valid;
		logic low_power_d;
		logic motion;
	} mso_wom_state_s;

	// Control block state
	typedef struct packed {
		logic [15:0] temp_word;
		mso_axes_s rate;
		logic accel_path_reset;
		logic temp_path_reset;
		logic rate_path_reset;
		logic motion_detect_enable;
		logic motion_compare_mode;
		logic fifo_enable;
		logic two_wire_disable;
		logic fifo_reset;
		logic fifo_reset_tick_seen;
		logic [MSO_DIV_W-1:0] div_count;
		logic int_tick;
		logic [7:0] rdata;
		logic rvalid;
	} mso_ctrl_state_s;

endpackage

// *** tb/mso_ctrl_monitor.sv ***
// Port checker for the sensor control block.
// Assumes one clock domain with active-low asynchronous reset.
`timescale 1ns/100ps
module mso_ctrl_monitor (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_read,
	input wire logic o_reg_rvalid,
	input wire logic o_accel_path_reset,
	input wire logic o_temp_path_reset,
	input wire logic o_rate_path_reset,
	input wire logic o_fifo_enable,
	input wire logic o_fifo_reset,
	input wire logic o_two_wire_disable
);
	import mso_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	logic wp;
	logic wu;
	// Writes to path reset and user control
	assign wp = i_reg_write && i_reg_addr == MSO_ADDR_PATH_RESET;
	assign wu = i_reg_write && i_reg_addr == MSO_ADDR_USER_CTRL;
	property p_rd; i_reg_read |=> o_reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("no answer");
	property p_rv; o_reg_rvalid |-> $past(i_reg_read); endproperty
	a_rv: assert property (p_rv) else $error("stray answer");
	property p_ac;
		wp && i_reg_wdata[MSO_BIT_ACCEL_PATH_RST] |=> o_accel_path_reset;
	endproperty
	a_ac: assert property (p_ac) else $error("no accel reset");
	property p_tp;
		wp && i_reg_wdata[MSO_BIT_TEMP_PATH_RST] |=> o_temp_path_reset;
	endproperty
	a_tp: assert property (p_tp) else $error("no temp reset");
	property p_cr;
		wu && i_reg_wdata[MSO_BIT_SIGNAL_CONDITIONING_RESET] |=> o_rate_path_reset
			&& o_accel_path_reset && o_temp_path_reset;
	endproperty
	a_cr: assert property (p_cr) else $error("no full reset");
	property p_rr;
		o_rate_path_reset |-> $past(wu && i_reg_wdata[MSO_BIT_SIGNAL_CONDITIONING_RESET]);
	endproperty
	a_rr: assert property (p_rr) else $error("stray reset");
	property p_fe;
		wu |=> o_fifo_enable == $past(i_reg_wdata[MSO_BIT_FIFO_ENABLE]);
	endproperty
	a_fe: assert property (p_fe) else $error("fifo enable");
	property p_tw;
		wu |=> o_two_wire_disable == $past(i_reg_wdata[MSO_BIT_TWO_WIRE_DIS]);
	endproperty
	a_tw: assert property (p_tw) else $error("two-wire bit");
	property p_fr;
		wu && i_reg_wdata[MSO_BIT_FIFO_RESET] |=> o_fifo_reset [*6];
	endproperty
	a_fr: assert property (p_fr) else $error("fifo reset short");
endmodule
bind mso_sensor_ctrl mso_ctrl_monitor u_mon (.i_clock, .i_arst_n,
	.i_reg_addr, .i_reg_write, .i_reg_wdata, .i_reg_read, .o_reg_rvalid,
	.o_accel_path_reset, .o_temp_path_reset, .o_rate_path_reset,
	.o_fifo_enable, .o_fifo_reset, .o_two_wire_disable);

// *** tb/mso_host_model.sv ***
// Host processor model driving decoded register accesses.
// Assumes strobes change at the falling edge of the system clock.
`timescale 1ns/100ps
module mso_host_model (
	// Clock and answer
	input wire logic i_clock,
	input wire logic i_rvalid,
	input wire logic [7:0] i_rdata,
	// Request
	output logic [7:0] o_addr,
	output logic o_write,
	output logic [7:0] o_wdata,
	output logic o_read
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_write = 1'b0;
		o_read = 1'b0;
	end
	// Raw temperature to degrees, offset and scale from the caller
	function automatic real to_degc(int w, int off, real sens);
		return (w - off) / sens + 25.0;
	endfunction
	// One write; bus shows inverted values once released
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		o_addr = a;
		o_wdata = (a == 8'h69) ? (d & 8'hfe) : d;
		o_write = 1'b1;
		@(negedge i_clock);
		o_write = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	// One read; answer taken one cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge i_clock);
		o_addr = a;
		o_read = 1'b1;
		@(negedge i_clock);
		o_read = 1'b0;
		ok = i_rvalid;
		d = i_rdata;
		o_addr = ~a;
	endtask
endmodule

// *** tb/tb.sv ***
// Testbench for the sensor control block with a host model.
// Assumes 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/100ps
module tb;
	import mso_pkg::*;
	logic clk = 0, rst_n = 0, wr, rd, rvalid, ok, w;
	logic [7:0] addr, wdata, rdata, d;
	logic [15:0] tw = '0;
	logic tv = 0, rv = 0, av = 0, lp = 0;
	mso_axes_s rw = '0, as = '0;
	logic [7:0] thr = 8'h32;
	logic ar, trs, rr, fe, fr, twd, wake_on_motion;
	int errors = 0, checked = 0, n, e, rf, hv, mt, mx, my, mz, m69, m6a;
	initial forever #5 clk = ~clk;
	mso_sensor_ctrl uut (.i_clock(clk), .i_arst_n(rst_n), .i_reg_addr(addr),
		.i_reg_write(wr), .i_reg_wdata(wdata), .i_reg_read(rd),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_temp_word(tw),
		.i_temp_valid(tv), .i_rate_word(rw), .i_rate_valid(rv),
		.i_accel_sample(as), .i_accel_valid(av), .i_low_power(lp),
		.i_motion_threshold(thr), .o_accel_path_reset(ar),
		.o_temp_path_reset(trs), .o_rate_path_reset(rr), .o_fifo_enable(fe),
		.o_fifo_reset(fr), .o_two_wire_disable(twd), .o_wake_on_motion(wake_on_motion));
	mso_host_model host (.i_clock(clk), .i_rvalid(rvalid), .i_rdata(rdata),
		.o_addr(addr), .o_write(wr), .o_wdata(wdata), .o_read(rd));
	// Comparison with count
	task chk(string s, logic [15:0] x, logic [15:0] g);
		checked++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask
	// Model register contents
	function automatic logic [7:0] ex(logic [7:0] a);
		logic [15:0] v;
		case (a)
			8'h41, 8'h42: v = mt[15:0];
			8'h43, 8'h44: v = mx[15:0];
			8'h45, 8'h46: v = my[15:0];
			8'h47, 8'h48: v = mz[15:0];
			8'h69: return m69[7:0] & 8'hc0;
			8'h6a: return m6a[7:0] & 8'h54;
			default: return 8'h00;
		endcase
		return a[0] ? v[15:8] : v[7:0];
	endfunction
	// Read all mapped places and a few unmapped ones
	task scan;
		for (int a = 8'h41; a <= 8'h6c; a++) begin
			if (a < 8'h49 || a > 8'h67) begin
				host.rd(a[7:0], d, ok);
				chk("rvalid", 1, ok);
				chk("rdata", ex(a[7:0]), d);
			end
		end
	endtask
	// One accel sample and the expected wake pulse
	task samp(int v);
		e = m69[7] && hv && ((v > rf ? v - rf : rf - v) > thr);
		if (m69[7] && (!hv || m69[6])) rf = v;
		hv = m69[7];
		@(negedge clk);
		as = {3{v[15:0]}};
		av = 1;
		@(negedge clk);
		av = 0;
		w = wake_on_motion;
		@(negedge clk);
		chk("wake", e, w | wake_on_motion);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		complete_run;
	end
	initial begin
		n = $urandom(28);
		{mt, mx, my, mz, m69, m6a, hv, rf} = '0;
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1;
		scan;
		// Random words, rates scaled by the sensitivity
		mt = $urandom;
		mx = 131 * (int'($urandom_range(499)) - 250);
		my = 131 * (int'($urandom_range(499)) - 250);
		mz = 131 * (int'($urandom_range(499)) - 250);
		tw = mt[15:0];
		rw = {mx[15:0], my[15:0], mz[15:0]};
		tv = 1;
		rv = 1;
		@(negedge clk);
		{tv, rv} = '0;
		host.wr(8'h41, 8'h5a);
		host.wr(8'h68, 8'h03);
		chk("path", 3'b110, {ar, trs, rr});
		scan;
		// Enabled mode 0, enabled mode 1, disabled
		for (int k = 0; k < 3; k++) begin
			m69 = (k < 2 ? 8'h81 : 8'h01) | (k == 1 ? 8'h40 : 8'h00);
			host.wr(8'h69, m69[7:0]);
			lp = 1;
			hv = 0;
			samp(0);
			samp(40);
			samp(80);
			// Accel path reset drops the reference; next sample becomes the new reference
			host.wr(8'h68, 8'h02);
			hv = 0;
			samp(200);
			samp(0);
			lp = 0;
			scan;
		end
		host.wr(8'h6a, 8'h54);
		chk("fifo", 3'b111, {fe, twd, fr});
		n = 0;
		while (fr === 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		chk("fifo_len", 1, n >= 6 && n <= 10);
		m6a = 8'h50;
		host.wr(8'h6a, 8'h51);
		chk("cond", 3'b111, {ar, trs, rr});
		{mt, mx, my, mz} = '0;
		scan;
		complete_run;
	end
endmodule
